// ==== spbp_pkg.sv ====
// spbp_pkg: constants, state type and parity helper for the secondary bus port
// assumes one clock domain, the secondary clock, for every user of this package
package spbp_pkg;

	localparam int          AD_W           = 32;
	localparam int          CBE_W          = 4;
	localparam int          LEN_W          = 4;
	localparam int          CNT_W          = 3;
	// cycles after frame start within which a target must claim
	localparam logic [2:0]  DEVSEL_TIMEOUT = 3'h5;
	localparam logic [2:0]  CNT_ZERO       = 3'h0;
	localparam logic [2:0]  CNT_ONE        = 3'h1;
	localparam logic [3:0]  LEN_ONE        = 4'h1;
	// write commands have this command bit set
	localparam int          CMD_DIR_BIT    = 0;
	localparam logic [31:0] AD_RST         = 32'h0;
	localparam logic [3:0]  CBE_RST        = 4'h0;
	localparam logic        PAR_RST        = 1'h0;
	localparam logic        DEASSERTED     = 1'h1;

	typedef enum logic [2:0] {
		ST_IDLE, ST_M_ADDR, ST_M_DATA, ST_M_TURN, ST_T_DEC, ST_T_DATA, ST_T_TURN
	} spbp_state_e;

	// parity bit that makes the ones across ad, cbe and parity even
	function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction

endpackage

// ==== spbp_sustain.sv ====
// spbp_sustain: one sustained tri-state control line driver
// assumes drive and assert_req are next-cycle values from the owner's state logic
module spbp_sustain (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// request from owner
	input  wire logic drive,
	input  wire logic assert_req,
	// pin
	output logic      pin_n,
	output logic      pin_oe
);
	logic drv_ff, nxt_drv, pin_ff, nxt_pin, oe_ff, nxt_oe;

	// after the owner lets go the line is driven high one more cycle, then floated
	always_comb begin
		nxt_drv = drive;
		nxt_oe  = drive | drv_ff;
		nxt_pin = drive ? ~assert_req : spbp_pkg::DEASSERTED;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drv_ff <= 1'h0;
			oe_ff  <= 1'h0;
			pin_ff <= spbp_pkg::DEASSERTED;
		end else begin
			drv_ff <= nxt_drv;
			oe_ff  <= nxt_oe;
			pin_ff <= nxt_pin;
		end
	end

	assign pin_n  = pin_ff;
	assign pin_oe = oe_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_release;
		pin_ff && oe_ff ##1 (!oe_ff || drv_ff);
	endsequence

	a_release_deassert: assert property ($fell(drv_ff) |-> s_release)
		else $error("line floated without one deasserted cycle");
	a_no_float_low: assert property ($fell(oe_ff) |-> $past(pin_ff))
		else $error("line floated straight from asserted");

endmodule // spbp_sustain

// ==== spbp_parity.sv ====
// spbp_parity: parity generation one cycle behind ad/cbe, and received-data check
// assumes ad/cbe drive values and enable come from flip-flops in the port
module spbp_parity (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// what the port drives on ad/cbe
	input  wire logic [31:0] ad_tx,
	input  wire logic [3:0]  cbe_tx,
	input  wire logic        ad_oe,
	// what the wires carry
	input  wire logic [31:0] ad_rx,
	input  wire logic [3:0]  cbe_rx,
	input  wire logic        par_rx,
	input  wire logic        chk,
	// parity pin and error pulse
	output logic             par_tx,
	output logic             par_oe,
	output logic             par_err
);
	logic        par_ff, nxt_par, oe_ff, nxt_oe, chk_ff, nxt_chk, err_ff, nxt_err;
	logic [31:0] ad_ff, nxt_ad;
	logic [3:0]  cbe_ff, nxt_cbe;

	// parity trails its data by a cycle, so its release trails too
	always_comb begin
		nxt_par = spbp_pkg::even_par(ad_tx, cbe_tx);
		nxt_oe  = ad_oe;
		nxt_chk = chk;
		nxt_ad  = chk ? ad_rx : ad_ff;
		nxt_cbe = chk ? cbe_rx : cbe_ff;
		nxt_err = chk_ff && (par_rx != spbp_pkg::even_par(ad_ff, cbe_ff));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			par_ff <= spbp_pkg::PAR_RST;
			oe_ff  <= 1'h1;
			chk_ff <= 1'h0;
			ad_ff  <= spbp_pkg::AD_RST;
			cbe_ff <= spbp_pkg::CBE_RST;
			err_ff <= 1'h0;
		end else begin
			par_ff <= nxt_par;
			oe_ff  <= nxt_oe;
			chk_ff <= nxt_chk;
			ad_ff  <= nxt_ad;
			cbe_ff <= nxt_cbe;
			err_ff <= nxt_err;
		end
	end

	assign par_tx  = par_ff;
	assign par_oe  = oe_ff;
	assign par_err = err_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_par_even: assert property ($past(ad_oe) |-> ^{$past(ad_tx), $past(cbe_tx), par_tx} == 1'h0)
		else $error("driven parity is not even");
	a_par_release: assert property ($fell(ad_oe) |-> par_oe ##1 (!par_oe || ad_oe))
		else $error("parity not released one cycle after ad");

endmodule // spbp_parity

// ==== spbp_port.sv ====
// spbp_port: secondary bus port, initiator and target state machine with pin drive
// assumes all bus inputs are synchronous to clock (the secondary clock) and that
// arbitration elsewhere supplies the internal grant
//
// Notes on behaviour
// - Parity makes ones across ad, cbe and parity an even count.
// - Address parity is valid the cycle after frame first asserts.
// - On reads we return, parity is driven one clock after target ready.
// - Parity floats one cycle after the ad lines float.
// - Idle with grant held, ad, cbe and parity are parked at valid levels.
// - A word moves only on an edge seeing both readies asserted.
// - Address and command in address phase, byte enables in data phases.
// - Frame stays asserted until the final data phase begins.
// - Once asserted, initiator or target ready holds until the phase ends.
// - Control lines are driven deasserted one cycle before floating.
// - As initiator, abort if no claim within 5 cycles of frame.
// - A target claims a transaction by asserting device select.
// - Stop from the target ends the transaction; the initiator obeys.
// - Lock is held across transactions meant to be atomic.
// - Everything here runs on the secondary clock only.
// - In reset controls float and ad, cbe, parity drive zero.
module spbp_port #(
	parameter int LEN_W = spbp_pkg::LEN_W
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// address/data, command/byte enables, parity pins
	input  wire logic [31:0]      sec_ad_rx,
	output logic      [31:0]      sec_ad_tx,
	output logic                  sec_ad_oe,
	input  wire logic [3:0]       secondary_cmd_byte_enables_rx,
	output logic      [3:0]       secondary_cmd_byte_enables_tx,
	output logic                  secondary_cmd_byte_enables_oe,
	input  wire logic             secondary_parity_line_rx,
	output logic                  secondary_parity_line_tx,
	output logic                  secondary_parity_line_oe,
	// sustained control pins
	input  wire logic             sec_frame_n_rx,
	output logic                  sec_frame_n_tx,
	output logic                  sec_frame_n_oe,
	input  wire logic             secondary_initiator_ready_n_rx,
	output logic                  secondary_initiator_ready_n_tx,
	output logic                  secondary_initiator_ready_n_oe,
	input  wire logic             secondary_target_ready_n_rx,
	output logic                  secondary_target_ready_n_tx,
	output logic                  secondary_target_ready_n_oe,
	input  wire logic             secondary_target_claim_n_rx,
	output logic                  secondary_target_claim_n_tx,
	output logic                  secondary_target_claim_n_oe,
	input  wire logic             sec_stop_n_rx,
	output logic                  sec_stop_n_tx,
	output logic                  sec_stop_n_oe,
	output logic                  sec_lock_n_tx,
	output logic                  sec_lock_n_oe,
	// internal grant
	input  wire logic             grant_n,
	// initiator requests
	input  wire logic             mst_req,
	input  wire logic [3:0]       mst_cmd,
	input  wire logic [31:0]      mst_addr,
	input  wire logic [LEN_W-1:0] mst_len,
	input  wire logic             mst_lock,
	input  wire logic [31:0]      mst_wdata,
	input  wire logic [3:0]       mst_be,
	output logic                  mst_wtake,
	output logic      [31:0]      mst_rdata,
	output logic                  mst_rvalid,
	output logic                  mst_done,
	output logic                  mst_stopped,
	output logic                  mst_abort,
	// target side
	output logic                  tgt_start,
	output logic      [31:0]      tgt_addr,
	output logic      [3:0]       tgt_cmd,
	input  wire logic             tgt_claim,
	input  wire logic             tgt_ready,
	input  wire logic [31:0]      tgt_rdata,
	input  wire logic             tgt_stop,
	output logic                  tgt_rtake,
	output logic                  tgt_wvalid,
	output logic      [31:0]      tgt_wdata,
	output logic      [3:0]       tgt_wbe,
	output logic                  tgt_done,
	// received data parity mismatch
	output logic                  data_parity_err
);
	spbp_pkg::spbp_state_e state_ff, nxt_state;
	logic [LEN_W-1:0]      len_ff, nxt_len;
	logic [2:0]            cnt_ff, nxt_cnt;
	logic [31:0]           ad_ff, nxt_ad, rdata_ff, nxt_rdata, taddr_ff, nxt_taddr, wdata_ff, nxt_wdata;
	logic [3:0]            cbe_ff, nxt_cbe, cmd_ff, nxt_cmd, wbe_ff, nxt_wbe;
	logic                  ad_oe_ff, nxt_ad_oe, cbe_oe_ff, nxt_cbe_oe, seen_ff, nxt_seen, lock_ff, nxt_lock;
	logic                  idle_q_ff, nxt_idle_q, rvalid_ff, nxt_rvalid, done_ff, nxt_done;
	logic                  stopped_ff, nxt_stopped, abort_ff, nxt_abort, tstart_ff, nxt_tstart;
	logic                  wvalid_ff, nxt_wvalid, tdone_ff, nxt_tdone;
	logic                  frm_drv, frm_as, irdy_drv, irdy_as, trdy_drv, trdy_as;
	logic                  dev_drv, dev_as, stop_drv, stop_as, chk;
	logic                  xfer, bus_idle, is_wr, our_trdy, our_stop, last_ph, t_end;

	// bus status seen on the wires, our own drive included
	assign xfer     = !secondary_initiator_ready_n_rx && !secondary_target_ready_n_rx;
	assign bus_idle = sec_frame_n_rx && secondary_initiator_ready_n_rx;
	assign is_wr    = cmd_ff[spbp_pkg::CMD_DIR_BIT];
	assign our_trdy = secondary_target_ready_n_oe && !secondary_target_ready_n_tx;
	assign our_stop = sec_stop_n_oe && !sec_stop_n_tx;
	assign last_ph  = sec_frame_n_tx; // frame already released means final phase
	assign t_end    = sec_frame_n_rx && !secondary_initiator_ready_n_rx && ((our_trdy && xfer) || our_stop);

	// next-state logic for both roles; pins are registered so they move with the state
	always_comb begin
		nxt_state = state_ff;   nxt_len = len_ff;     nxt_cnt = cnt_ff;     nxt_ad = ad_ff;
		nxt_cbe = cbe_ff;       nxt_cmd = cmd_ff;     nxt_ad_oe = ad_oe_ff; nxt_cbe_oe = cbe_oe_ff;
		nxt_seen = seen_ff;     nxt_lock = lock_ff;   nxt_rdata = rdata_ff; nxt_taddr = taddr_ff;
		nxt_wdata = wdata_ff;   nxt_wbe = wbe_ff;     nxt_idle_q = bus_idle;
		nxt_rvalid = 1'h0;      nxt_done = 1'h0;      nxt_stopped = stopped_ff;
		nxt_abort = 1'h0;       nxt_tstart = 1'h0;    nxt_wvalid = 1'h0;    nxt_tdone = 1'h0;
		frm_drv = 1'h0;  frm_as = 1'h0;  irdy_drv = 1'h0; irdy_as = 1'h0; trdy_drv = 1'h0;
		trdy_as = 1'h0;  dev_drv = 1'h0; dev_as = 1'h0;   stop_drv = 1'h0; stop_as = 1'h0;
		mst_wtake = 1'h0; tgt_rtake = 1'h0; chk = 1'h0;
		case (state_ff)
			spbp_pkg::ST_IDLE: begin
				nxt_ad_oe  = !grant_n && bus_idle;
				nxt_cbe_oe = !grant_n && bus_idle;
				if (!mst_lock)
					nxt_lock = 1'h0;
				if (mst_req && !grant_n && bus_idle) begin
					nxt_state = spbp_pkg::ST_M_ADDR;
					nxt_ad = mst_addr;
					nxt_cbe = mst_cmd;
					nxt_cmd = mst_cmd;
					nxt_len = mst_len;
					nxt_cnt = spbp_pkg::CNT_ZERO;
					nxt_seen = 1'h0;
					nxt_lock = mst_lock;
					nxt_stopped = 1'h0;
					frm_drv = 1'h1;
					frm_as = 1'h1;
				end else if (idle_q_ff && !sec_frame_n_rx) begin
					// another initiator's address phase: latch it for decode
					nxt_state = spbp_pkg::ST_T_DEC;
					nxt_taddr = sec_ad_rx;
					nxt_cmd = secondary_cmd_byte_enables_rx;
					nxt_tstart = 1'h1;
					nxt_ad_oe = 1'h0;
					nxt_cbe_oe = 1'h0;
				end
			end
			spbp_pkg::ST_M_ADDR: begin
				nxt_state = spbp_pkg::ST_M_DATA;
				nxt_cnt = cnt_ff + spbp_pkg::CNT_ONE;
				frm_drv = 1'h1;
				frm_as = len_ff > spbp_pkg::LEN_ONE;
				irdy_drv = 1'h1;
				irdy_as = 1'h1;
				nxt_cbe = mst_be;
				nxt_ad_oe = is_wr; // reads turn the ad lines around
				nxt_ad = mst_wdata;
				mst_wtake = is_wr;
			end
			spbp_pkg::ST_M_DATA: begin
				frm_drv = 1'h1;
				frm_as = !last_ph;
				irdy_drv = 1'h1;
				irdy_as = 1'h1;
				if (cnt_ff != spbp_pkg::DEVSEL_TIMEOUT)
					nxt_cnt = cnt_ff + spbp_pkg::CNT_ONE;
				if (!secondary_target_claim_n_rx)
					nxt_seen = 1'h1;
				if (!seen_ff && secondary_target_claim_n_rx && cnt_ff == spbp_pkg::DEVSEL_TIMEOUT) begin
					// nobody claimed: master abort
					nxt_state = spbp_pkg::ST_M_TURN;
					frm_drv = 1'h0;
					irdy_drv = 1'h0;
					nxt_ad_oe = 1'h0;
					nxt_cbe_oe = 1'h0;
					nxt_abort = 1'h1;
					nxt_done = 1'h1;
				end else begin
					if (xfer) begin
						nxt_len = len_ff - spbp_pkg::LEN_ONE;
						nxt_rvalid = !is_wr;
						nxt_rdata = sec_ad_rx;
						chk = !is_wr;
					end
					if (last_ph && (xfer || !sec_stop_n_rx)) begin
						nxt_state = spbp_pkg::ST_M_TURN;
						frm_drv = 1'h0;
						irdy_drv = 1'h0;
						nxt_ad_oe = 1'h0;
						nxt_cbe_oe = 1'h0;
						nxt_done = 1'h1;
						nxt_stopped = !sec_stop_n_rx;
					end else if (!sec_stop_n_rx) begin
						frm_as = 1'h0;
					end else if (xfer) begin
						frm_as = nxt_len > spbp_pkg::LEN_ONE;
						nxt_ad = mst_wdata;
						nxt_cbe = mst_be;
						mst_wtake = is_wr;
					end
				end
			end
			spbp_pkg::ST_T_DEC: begin
				if (tgt_claim && !sec_frame_n_rx) begin
					nxt_state = spbp_pkg::ST_T_DATA;
					dev_drv = 1'h1;
					dev_as = 1'h1;
					stop_drv = 1'h1;
					trdy_drv = 1'h1;
				end else begin
					nxt_state = spbp_pkg::ST_IDLE;
				end
			end
			spbp_pkg::ST_T_DATA: begin
				dev_drv = 1'h1;
				dev_as = 1'h1;
				stop_drv = 1'h1;
				stop_as = our_stop || tgt_stop;
				trdy_drv = 1'h1;
				trdy_as = our_trdy && !xfer;
				nxt_ad_oe = !is_wr;
				if (our_trdy && xfer) begin
					nxt_wvalid = is_wr;
					nxt_wdata = sec_ad_rx;
					nxt_wbe = secondary_cmd_byte_enables_rx;
					chk = is_wr;
				end
				if (t_end) begin
					nxt_state = spbp_pkg::ST_T_TURN;
					dev_drv = 1'h0;
					stop_drv = 1'h0;
					trdy_drv = 1'h0;
					nxt_ad_oe = 1'h0;
					nxt_tdone = 1'h1;
				end else if ((!our_trdy || xfer) && tgt_ready && !stop_as) begin
					trdy_as = 1'h1;
					nxt_ad = tgt_rdata;
					tgt_rtake = !is_wr;
				end
			end
			default: begin
				// turnaround: lines go to their one deasserted cycle, then float
				nxt_state = spbp_pkg::ST_IDLE;
				nxt_ad_oe = 1'h0;
				nxt_cbe_oe = 1'h0;
			end
		endcase
	end

	// single secondary clock domain; ad, cbe driven to zero under reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= spbp_pkg::ST_IDLE;  len_ff <= '0;          cnt_ff <= spbp_pkg::CNT_ZERO;
			ad_ff <= spbp_pkg::AD_RST;      cbe_ff <= spbp_pkg::CBE_RST;
			ad_oe_ff <= 1'h1;               cbe_oe_ff <= 1'h1;    cmd_ff <= spbp_pkg::CBE_RST;
			seen_ff <= 1'h0;                lock_ff <= 1'h0;      idle_q_ff <= 1'h0;
			rdata_ff <= spbp_pkg::AD_RST;   taddr_ff <= spbp_pkg::AD_RST;
			wdata_ff <= spbp_pkg::AD_RST;   wbe_ff <= spbp_pkg::CBE_RST;
			rvalid_ff <= 1'h0;  done_ff <= 1'h0;   stopped_ff <= 1'h0; abort_ff <= 1'h0;
			tstart_ff <= 1'h0;  wvalid_ff <= 1'h0; tdone_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;  len_ff <= nxt_len;      cnt_ff <= nxt_cnt;
			ad_ff <= nxt_ad;        cbe_ff <= nxt_cbe;
			ad_oe_ff <= nxt_ad_oe;  cbe_oe_ff <= nxt_cbe_oe; cmd_ff <= nxt_cmd;
			seen_ff <= nxt_seen;    lock_ff <= nxt_lock;    idle_q_ff <= nxt_idle_q;
			rdata_ff <= nxt_rdata;  taddr_ff <= nxt_taddr;
			wdata_ff <= nxt_wdata;  wbe_ff <= nxt_wbe;
			rvalid_ff <= nxt_rvalid; done_ff <= nxt_done;   stopped_ff <= nxt_stopped; abort_ff <= nxt_abort;
			tstart_ff <= nxt_tstart; wvalid_ff <= nxt_wvalid; tdone_ff <= nxt_tdone;
		end
	end

	// sustained control line drivers
	spbp_sustain u_frame (.clock(clock), .rst_n(rst_n), .drive(frm_drv), .assert_req(frm_as),
		.pin_n(sec_frame_n_tx), .pin_oe(sec_frame_n_oe));
	spbp_sustain u_irdy (.clock(clock), .rst_n(rst_n), .drive(irdy_drv), .assert_req(irdy_as),
		.pin_n(secondary_initiator_ready_n_tx), .pin_oe(secondary_initiator_ready_n_oe));
	spbp_sustain u_trdy (.clock(clock), .rst_n(rst_n), .drive(trdy_drv), .assert_req(trdy_as),
		.pin_n(secondary_target_ready_n_tx), .pin_oe(secondary_target_ready_n_oe));
	spbp_sustain u_claim (.clock(clock), .rst_n(rst_n), .drive(dev_drv), .assert_req(dev_as),
		.pin_n(secondary_target_claim_n_tx), .pin_oe(secondary_target_claim_n_oe));
	spbp_sustain u_stop (.clock(clock), .rst_n(rst_n), .drive(stop_drv), .assert_req(stop_as),
		.pin_n(sec_stop_n_tx), .pin_oe(sec_stop_n_oe));
	spbp_sustain u_lock (.clock(clock), .rst_n(rst_n), .drive(nxt_lock), .assert_req(nxt_lock),
		.pin_n(sec_lock_n_tx), .pin_oe(sec_lock_n_oe));

	// parity follows ad/cbe drive one cycle later
	spbp_parity u_par (.clock(clock), .rst_n(rst_n), .ad_tx(ad_ff), .cbe_tx(cbe_ff), .ad_oe(ad_oe_ff),
		.ad_rx(sec_ad_rx), .cbe_rx(secondary_cmd_byte_enables_rx), .par_rx(secondary_parity_line_rx),
		.chk(chk), .par_tx(secondary_parity_line_tx), .par_oe(secondary_parity_line_oe),
		.par_err(data_parity_err));

	assign sec_ad_tx = ad_ff;
	assign sec_ad_oe = ad_oe_ff;
	assign secondary_cmd_byte_enables_tx = cbe_ff;
	assign secondary_cmd_byte_enables_oe = cbe_oe_ff;
	assign mst_rdata = rdata_ff;   assign mst_rvalid = rvalid_ff; assign mst_done = done_ff;
	assign mst_stopped = stopped_ff; assign mst_abort = abort_ff;
	assign tgt_start = tstart_ff;  assign tgt_addr = taddr_ff;    assign tgt_cmd = cmd_ff;
	assign tgt_wvalid = wvalid_ff; assign tgt_wdata = wdata_ff;   assign tgt_wbe = wbe_ff;
	assign tgt_done = tdone_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_rvalid_xfer: assert property (mst_rvalid |-> $past(xfer) && $past(state_ff) == spbp_pkg::ST_M_DATA)
		else $error("read data without a transfer edge");
	a_abort_time: assert property (state_ff == spbp_pkg::ST_M_DATA && cnt_ff == spbp_pkg::DEVSEL_TIMEOUT
		&& !seen_ff && secondary_target_claim_n_rx |=> mst_abort && state_ff == spbp_pkg::ST_M_TURN)
		else $error("missing master abort at claim timeout");
	a_abort_cause: assert property (mst_abort |-> $past(!seen_ff) && $past(cnt_ff) == spbp_pkg::DEVSEL_TIMEOUT)
		else $error("abort flagged without timeout");
	a_park_bus: assert property (state_ff == spbp_pkg::ST_IDLE && !grant_n && bus_idle && !mst_req
		|=> sec_ad_oe && secondary_cmd_byte_enables_oe ##1 secondary_parity_line_oe)
		else $error("bus not parked under grant");
	a_addr_cmd: assert property (state_ff == spbp_pkg::ST_M_ADDR |-> secondary_cmd_byte_enables_tx == cmd_ff
		&& !sec_frame_n_tx ##1 secondary_parity_line_oe)
		else $error("address phase command or parity wrong");
	a_frame_last: assert property (state_ff == spbp_pkg::ST_M_DATA && !sec_frame_n_tx
		&& sec_stop_n_rx |-> len_ff > spbp_pkg::LEN_ONE)
		else $error("frame held in final phase");
	a_trdy_hold: assert property (state_ff == spbp_pkg::ST_T_DATA && our_trdy && !xfer && !t_end
		|=> our_trdy)
		else $error("target ready dropped before transfer");
	a_read_par: assert property (state_ff == spbp_pkg::ST_T_DATA && !is_wr && $rose(our_trdy)
		|=> secondary_parity_line_oe)
		else $error("read parity not driven after target ready");

endmodule // spbp_port

// ==== spbp_far_target.sv ====
// spbp_far_target: behavioural target on the secondary bus, facing the port
// assumes pulled-up control lines; the bench resolves every shared wire
module spbp_far_target (
	// clock, reset, behaviour knobs
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        claim_en,
	input  wire logic        stop_en,
	// resolved wires
	input  wire logic        frame_w,
	input  wire logic        irdy_w,
	input  wire logic [3:0]  cbe_w,
	// target drive
	output logic      [31:0] ad_o,
	output logic             ad_oe,
	output logic             par_o,
	output logic             par_oe,
	output logic             devsel_n,
	output logic             trdy_n,
	output logic             stop_n,
	output logic             ctl_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        fr_q;
	logic        act;
	logic        rd;
	logic        ending;
	logic [31:0] word;
	// claim on frame fall, answer a cycle later, end on the final phase
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{fr_q, act, rd, ending, ad_oe, par_oe, ctl_oe} <= '0;
			{devsel_n, trdy_n, stop_n, par_o} <= 4'hF;
			ad_o <= 32'h0;
			word <= 32'h0;
		end else begin
			fr_q   <= frame_w;
			par_o  <= ^{ad_o, cbe_w};
			par_oe <= ad_oe;
			if (ending) begin
				ctl_oe <= 1'b0;
				ending <= 1'b0;
			end
			if (!act && fr_q && !frame_w && claim_en) begin
				act  <= 1'b1;
				rd   <= !cbe_w[0];
				word <= 32'hA5000000;
			end else if (act) begin
				ctl_oe   <= 1'b1;
				devsel_n <= 1'b0;
				stop_n   <= !stop_en;
				trdy_n   <= stop_en;
				ad_oe    <= rd;
				ad_o     <= word;
				if (!trdy_n && !irdy_w) begin
					word <= word + 32'h1;
					ad_o <= word + 32'h1;
				end
				// stop ends on frame release; otherwise the final transfer ends it
				if (frame_w && (!stop_n || (!trdy_n && !irdy_w))) begin
					act                        <= 1'b0;
					ending                     <= 1'b1;
					{devsel_n, trdy_n, stop_n} <= 3'h7;
					ad_oe                      <= 1'b0;
				end
			end
		end
	end
endmodule // spbp_far_target

// ==== test_secondary_pci_bus_port.sv ====
// test_secondary_pci_bus_port: self-checking bench, port as initiator
// assumes pulled-up controls; undriven data lines show their last value inverted
module test_secondary_pci_bus_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, grant_n, mst_req, mst_lock, claim_en, stop_en, par_q;
	logic [3:0]  mst_cmd, mst_len, mst_be, cbe_tx, cbe_q;
	logic [31:0] mst_addr, ad_tx, ad_q, rdata, f_ad;
	logic [31:0] wd = 32'h12340000;
	logic        ad_oe, cbe_oe, par_tx, par_oe, fr_tx, fr_oe, ir_tx, ir_oe, tr_tx, tr_oe, dv_tx, dv_oe;
	logic        sp_tx, sp_oe, lk_tx, lk_oe, wtk, rvalid, done, stopped, abort, perr;
	logic        f_ad_oe, f_par, f_par_oe, f_dv, f_tr, f_sp, f_oe, ab, stp, lk, pe;
	int          failures, check_count, cyc, n_rd, n_wt, a_off, p_off;
	wire  [31:0] ad_w  = ad_oe ? ad_tx : (f_ad_oe ? f_ad : ~ad_q);
	wire  [3:0]  cbe_w = cbe_oe ? cbe_tx : ~cbe_q;
	wire         par_w = par_oe ? par_tx : (f_par_oe ? f_par : ~par_q);
	wire         fr_w  = fr_oe ? fr_tx : 1'b1;
	wire         ir_w  = ir_oe ? ir_tx : 1'b1;
	wire         tr_w  = tr_oe ? tr_tx : (f_oe ? f_tr : 1'b1);
	wire         dv_w  = dv_oe ? dv_tx : (f_oe ? f_dv : 1'b1);
	wire         sp_w  = sp_oe ? sp_tx : (f_oe ? f_sp : 1'b1);
	// 8 ns clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// last-value memory so a released data line never looks stable
	always @(posedge clock) begin
		ad_q  <= ad_w;
		cbe_q <= cbe_w;
		par_q <= par_w;
	end
	// next write word once the current one is taken
	always @(posedge clock) if (wtk) wd <= wd + 32'h1;
	spbp_port uut (.clock(clock), .rst_n(rst_n), .sec_ad_rx(ad_w), .sec_ad_tx(ad_tx), .sec_ad_oe(ad_oe),
		.secondary_cmd_byte_enables_rx(cbe_w), .secondary_cmd_byte_enables_tx(cbe_tx),
		.secondary_cmd_byte_enables_oe(cbe_oe), .secondary_parity_line_rx(par_w),
		.secondary_parity_line_tx(par_tx), .secondary_parity_line_oe(par_oe),
		.sec_frame_n_rx(fr_w), .sec_frame_n_tx(fr_tx), .sec_frame_n_oe(fr_oe),
		.secondary_initiator_ready_n_rx(ir_w), .secondary_initiator_ready_n_tx(ir_tx),
		.secondary_initiator_ready_n_oe(ir_oe), .secondary_target_ready_n_rx(tr_w),
		.secondary_target_ready_n_tx(tr_tx), .secondary_target_ready_n_oe(tr_oe),
		.secondary_target_claim_n_rx(dv_w), .secondary_target_claim_n_tx(dv_tx),
		.secondary_target_claim_n_oe(dv_oe), .sec_stop_n_rx(sp_w), .sec_stop_n_tx(sp_tx),
		.sec_stop_n_oe(sp_oe), .sec_lock_n_tx(lk_tx), .sec_lock_n_oe(lk_oe), .grant_n(grant_n),
		.mst_req(mst_req), .mst_cmd(mst_cmd), .mst_addr(mst_addr), .mst_len(mst_len), .mst_lock(mst_lock),
		.mst_wdata(wd), .mst_be(mst_be), .mst_wtake(wtk), .mst_rdata(rdata), .mst_rvalid(rvalid),
		.mst_done(done), .mst_stopped(stopped), .mst_abort(abort), .tgt_start(), .tgt_addr(),
		.tgt_cmd(), .tgt_claim(1'b0), .tgt_ready(1'b0), .tgt_rdata(32'h0), .tgt_stop(1'b0),
		.tgt_rtake(), .tgt_wvalid(), .tgt_wdata(), .tgt_wbe(), .tgt_done(), .data_parity_err(perr));
	spbp_far_target far (.clock(clock), .rst_n(rst_n), .claim_en(claim_en), .stop_en(stop_en),
		.frame_w(fr_w), .irdy_w(ir_w), .cbe_w(cbe_w), .ad_o(f_ad), .ad_oe(f_ad_oe), .par_o(f_par),
		.par_oe(f_par_oe), .devsel_n(f_dv), .trdy_n(f_tr), .stop_n(f_sp), .ctl_oe(f_oe));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic tick;
		@(posedge clock);
		#1;
	endtask
	// one initiator transaction, watched cycle by cycle until three cycles past done
	task automatic txn(input logic [3:0] cmd, input logic [3:0] len, input logic lock);
		int   k;
		logic pf, pt;
		@(posedge clock);
		{mst_req, mst_cmd, mst_addr, mst_len, mst_lock, grant_n} <= {1'b1, cmd, 32'h80001230, len, lock, 1'b0};
		for (k = 0; k < 20 && !(fr_oe && !fr_tx); k++)
			tick;
		// request never started a frame: count it and end the run
		if (k == 20) begin
			failures++;
			stop_test;
		end
		check(ad_tx, 32'h80001230);
		check(cbe_tx, cmd);
		n_wt = int'(wtk);
		@(posedge clock);
		{mst_req, grant_n} <= 2'h1;
		#1;
		check(par_tx, ^{32'h80001230, cmd});
		{n_rd, cyc, a_off, p_off, pf, pe} = {32'd0, -32'sd1, -32'sd1, -32'sd1, 2'h0};
		for (k = 0; k < 60 && !(cyc >= 0 && k == cyc + 3); k++) begin
			if (rvalid) begin
				check(rdata, 32'hA5000000 + n_rd);
				n_rd++;
			end
			n_wt += int'(wtk);
			pe |= perr;
			if (!ad_oe && a_off < 0) a_off = k;
			if (!par_oe && p_off < 0) p_off = k;
			if (pf && !fr_oe) check(pt, 1'b1);
			pf = fr_oe;
			pt = fr_tx;
			if (done && cyc < 0) begin
				{ab, stp, lk} = {abort, stopped, lk_oe && !lk_tx};
				cyc = k;
			end
			tick;
		end
		if (cyc < 0) begin
			failures++;
			stop_test;
		end
		check(p_off, a_off + 1);
	endtask
	initial begin
		{rst_n, grant_n, mst_req, mst_lock, claim_en, stop_en} = 6'h02;
		{mst_cmd, mst_len, mst_be, mst_addr} = {12'h0, 4'hF, 32'h0};
		{failures, check_count} = '0;
		repeat (5) @(posedge clock);
		#1;
		check({fr_oe, ir_oe, tr_oe, dv_oe, sp_oe, lk_oe}, 6'h0);
		check({ad_oe, cbe_oe, par_oe, ad_tx, cbe_tx, par_tx}, {3'h7, 37'h0});
		@(posedge clock) rst_n <= 1'b1;
		tick;
		tick;
		check({ad_oe, cbe_oe, par_oe}, 3'h7);
		check(par_tx, ^{ad_tx, cbe_tx});
		txn(4'h7, 4'h1, 1'b1);
		check({n_wt, ab, stp, lk}, {32'd1, 3'h1});
		txn(4'h6, 4'h2, 1'b0);
		check({n_rd, pe, ab}, {32'd2, 2'h0});
		txn(4'h7, 4'h3, 1'b0);
		check(n_wt, 3);
		@(posedge clock) stop_en <= 1'b1;
		txn(4'h6, 4'h3, 1'b0);
		check({n_rd, stp}, 33'h1);
		@(posedge clock) {claim_en, stop_en} <= 2'h0;
		txn(4'h7, 4'h1, 1'b0);
		check({ab, cyc}, {1'b1, 32'd5});
		stop_test;
	end
endmodule // test_secondary_pci_bus_port
